/* File: design/tmon_pkg.sv */
// Shared constants and types of the temperature result and limit monitor
package tmon_pkg;

	// ----------------------------------------------------------------
	// Result format and averaging
	// ----------------------------------------------------------------
	localparam int         RES_W       = 11;
	localparam int         AVG_LOG2    = 5;          // 32 samples
	localparam logic [10:0] RES_RESET  = 11'h400;    // -128 degrees
	localparam logic [8:0] THR_HYST    = 9'h005;     // 5 degree rearm band

	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam logic [5:0] A_CFG1      = 6'h00;
	localparam logic [5:0] A_CFG2      = 6'h01;
	localparam logic [5:0] A_STAT1     = 6'h02;
	localparam logic [5:0] A_STAT2     = 6'h03;
	localparam logic [5:0] A_CFG3      = 6'h04;
	localparam logic [5:0] A_FRAC      = 6'h06;
	localparam logic [5:0] A_LOC       = 6'h0a;
	localparam logic [5:0] A_REM       = 6'h0b;
	localparam logic [5:0] A_LHI       = 6'h10;
	localparam logic [5:0] A_LLO       = 6'h11;
	localparam logic [5:0] A_LCRIT     = 6'h12;
	localparam logic [5:0] A_RHI       = 6'h13;
	localparam logic [5:0] A_RLO       = 6'h14;
	localparam logic [5:0] A_RCRIT     = 6'h15;
	localparam logic [5:0] A_PSV       = 6'h16;
	localparam logic [5:0] A_THR       = 6'h17;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int B_START    = 0;   // cfg1
	localparam int B_FANMAX   = 1;   // cfg1: fan follows faster of two
	localparam int B_LOCAL_RANGE_IRQ_ENABLE    = 0;   // cfg2
	localparam int B_REMOTE_RANGE_IRQ_ENABLE    = 1;
	localparam int B_PASSIVE_COOLING_IRQ_ENABLE    = 2;
	localparam int B_THRIE    = 3;
	localparam int B_THRFAN   = 0;   // cfg3

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] CFG_RESET   = 8'h00;
	localparam logic [7:0] HI_RESET    = 8'h50;
	localparam logic [7:0] LO_RESET    = 8'h00;
	localparam logic [7:0] CRIT_RESET  = 8'h64;
	localparam logic [7:0] PSV_RESET   = 8'h28;
	localparam logic [7:0] THR_RESET   = 8'h5a;

	// Register port request, one access per cycle
	typedef struct packed {
		logic       rd;
		logic       wr;
		logic [5:0] addr;
		logic [7:0] wdata;
	} tmon_req_t;

	// One converter sample
	typedef struct packed {
		logic        valid;
		logic        remote;
		logic [10:0] data;
	} tmon_sample_t;

endpackage : tmon_pkg

/* File: design/tmon_avg.sv */
// Block averager for one sensor channel
`timescale 1ns/1ns
module tmon_avg #(
	parameter int W      = 11,
	parameter int N_LOG2 = 5
) (
	input  wire logic         clk,      // Monitor clock
	input  wire logic         rst_b,    // Async reset, active low
	input  wire logic         clear,    // Drop partial sum
	input  wire logic         in_valid, // Sample strobe
	input  wire logic [W-1:0] in_data,  // Two's complement sample
	output logic      [W-1:0] avg,      // Latest average
	output logic              done      // Pulse when avg updates
);

	localparam int SW = W + N_LOG2;

	// ----------------------------------------------------------------
	// Elaboration check
	// ----------------------------------------------------------------
	if (N_LOG2 < 1 || W != tmon_pkg::RES_W) begin : g_chk
		$error("tmon_avg: unsupported width or depth");
	end

	logic signed [SW-1:0] sum_reg;
	logic [N_LOG2-1:0]    cnt_reg;
	logic signed [SW-1:0] total;

	// Sign extend each sample into the running sum
	assign total = sum_reg + SW'($signed(in_data));

	// Accumulate, and on the last sample divide by a shift
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			sum_reg <= '0;
			cnt_reg <= '0;
			avg     <= tmon_pkg::RES_RESET;
			done    <= 1'b0;
		end else begin
			done <= 1'b0;
			if (clear) begin
				sum_reg <= '0;
				cnt_reg <= '0;
			end else if (in_valid) begin
				cnt_reg <= cnt_reg + 1'b1;
				if (&cnt_reg) begin
					// Upper bits are the floor of sum / 2^N_LOG2
					avg     <= total[SW-1:N_LOG2];
					sum_reg <= '0;
					done    <= 1'b1;
				end else begin
					sum_reg <= total;
				end
			end
		end
	end

endmodule : tmon_avg

/* File: design/tmon_monitor.sv */
// Temperature result store, coherent readout and limit monitor
//
// Behaviour
// RL1 - Average 32 converter results per sensor, store newest average.
// RL2 - Conversions halt while start bit is zero, run while one.
// RL3 - Upper eight result bits in whole byte, lower three in shared byte.
// RL4 - Results are two's complement, -128 to +127 degrees.
// RL5 - Whole byte registers readable any time, any order.
// RL6 - Host reads fraction byte, then remote whole byte.
// RL7 - Fraction byte read freezes results until remote whole byte read.
// RL8 - High flag sets when temperature at or above high limit.
// RL9 - Low flag sets when temperature at or below low limit.
// RL10 - Local out-of-range flag follows local high/low; alert if enabled.
// RL11 - Remote out-of-range flag follows remote high/low; alert if enabled.
// RL12 - At critical limit: set flag, drive over-temperature pin low, alert.
// RL13 - Remote fan mode: passive cooling when remote at or below limit.
// RL14 - Faster-speed mode: passive cooling only when both at or below.
// RL15 - Passive cooling sets flag in status 2; alert if enabled.
// RL16 - Status 2 read clears passive flag; it resets next cycle.
// RL17 - At throttle limit: set flag, throttle pin low, alert if enabled.
// RL18 - Status 1 read clears throttle flags; rearm 5 degrees below.
// RL19 - Throttle-forces-fan enable makes either throttle flag force full fan.
// RL20 - No detections or alerts before first full monitoring cycle.
// RL21 - Compare once per cycle; limits are signed whole-degree bytes.
`timescale 1ns/1ns
module tmon_monitor (
	input  wire logic                 clk,        // Monitor clock
	input  wire logic                 rst_b,      // Async reset, low
	input  wire tmon_pkg::tmon_req_t  reg_req,    // Register access
	output logic [7:0]                reg_rdata,  // Read data, next cycle
	input  wire tmon_pkg::tmon_sample_t sample,   // Converter output
	output logic                      adc_run,    // Converter enable
	output logic                      over_temperature_pin_b, // Low=crit
	output logic                      cpu_throttle_pin_b,     // Low=hot
	output logic                      alert_b,    // Alert request, low
	output logic                      fan_stop,   // Passive cooling
	output logic                      fan_full    // Forced full speed
);

	// ----------------------------------------------------------------
	// Configuration and limit registers
	// ----------------------------------------------------------------
	logic [7:0] cfg1_reg, cfg2_reg, cfg3_reg;
	logic [7:0] lhi_reg, llo_reg, lcrit_reg;
	logic [7:0] rhi_reg, rlo_reg, rcrit_reg;
	logic [7:0] psv_reg, thr_reg;
	logic       start;

	assign start   = cfg1_reg[tmon_pkg::B_START];
	assign adc_run = start; // RL2

	// Software writes; result and status registers ignore writes
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cfg1_reg  <= tmon_pkg::CFG_RESET;
			cfg2_reg  <= tmon_pkg::CFG_RESET;
			cfg3_reg  <= tmon_pkg::CFG_RESET;
			lhi_reg   <= tmon_pkg::HI_RESET;
			llo_reg   <= tmon_pkg::LO_RESET;
			lcrit_reg <= tmon_pkg::CRIT_RESET;
			rhi_reg   <= tmon_pkg::HI_RESET;
			rlo_reg   <= tmon_pkg::LO_RESET;
			rcrit_reg <= tmon_pkg::CRIT_RESET;
			psv_reg   <= tmon_pkg::PSV_RESET;
			thr_reg   <= tmon_pkg::THR_RESET;
		end else if (reg_req.wr) begin
			case (reg_req.addr)
				tmon_pkg::A_CFG1:  cfg1_reg  <= reg_req.wdata;
				tmon_pkg::A_CFG2:  cfg2_reg  <= reg_req.wdata;
				tmon_pkg::A_CFG3:  cfg3_reg  <= reg_req.wdata;
				tmon_pkg::A_LHI:   lhi_reg   <= reg_req.wdata;
				tmon_pkg::A_LLO:   llo_reg   <= reg_req.wdata;
				tmon_pkg::A_LCRIT: lcrit_reg <= reg_req.wdata;
				tmon_pkg::A_RHI:   rhi_reg   <= reg_req.wdata;
				tmon_pkg::A_RLO:   rlo_reg   <= reg_req.wdata;
				tmon_pkg::A_RCRIT: rcrit_reg <= reg_req.wdata;
				tmon_pkg::A_PSV:   psv_reg   <= reg_req.wdata;
				tmon_pkg::A_THR:   thr_reg   <= reg_req.wdata;
				default: ;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Averaging, one instance per sensor
	// ----------------------------------------------------------------
	logic [10:0] loc_avg, rem_avg;
	logic        loc_done, rem_done;

	// Stopping drops partial sums so a restart begins a clean block
	tmon_avg #(.W(tmon_pkg::RES_W), .N_LOG2(tmon_pkg::AVG_LOG2)) u_loc (
		.clk      (clk),
		.rst_b    (rst_b),
		.clear    (!start),
		.in_valid (sample.valid && !sample.remote && start), // RL1 RL2
		.in_data  (sample.data),
		.avg      (loc_avg),
		.done     (loc_done)
	);

	tmon_avg #(.W(tmon_pkg::RES_W), .N_LOG2(tmon_pkg::AVG_LOG2)) u_rem (
		.clk      (clk),
		.rst_b    (rst_b),
		.clear    (!start),
		.in_valid (sample.valid && sample.remote && start), // RL1 RL2
		.in_data  (sample.data),
		.avg      (rem_avg),
		.done     (rem_done)
	);

	// ----------------------------------------------------------------
	// Monitoring cycle: both sensors have a fresh average
	// ----------------------------------------------------------------
	logic loc_got, rem_got, eval;

	assign eval = loc_got && rem_got; // RL20 RL21

	// A new average in the evaluation cycle still counts for the next
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			loc_got <= 1'b0;
			rem_got <= 1'b0;
		end else if (!start) begin
			loc_got <= 1'b0;
			rem_got <= 1'b0;
		end else begin
			loc_got <= loc_done || (loc_got && !eval);
			rem_got <= rem_done || (rem_got && !eval);
		end
	end

	// ----------------------------------------------------------------
	// Visible results with coherent freeze
	// ----------------------------------------------------------------
	logic [10:0] loc_vis_reg, rem_vis_reg;
	logic        freeze_reg;
	logic        rd_frac, rd_rem, rd_st1, rd_st2;

	assign rd_frac = reg_req.rd && reg_req.addr == tmon_pkg::A_FRAC;
	assign rd_rem  = reg_req.rd && reg_req.addr == tmon_pkg::A_REM;
	assign rd_st1  = reg_req.rd && reg_req.addr == tmon_pkg::A_STAT1;
	assign rd_st2  = reg_req.rd && reg_req.addr == tmon_pkg::A_STAT2;

	// Freeze holds from the fraction read to the remote whole read
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			freeze_reg <= 1'b0;
		else if (rd_rem)
			freeze_reg <= 1'b0; // RL6 RL7
		else if (rd_frac)
			freeze_reg <= 1'b1; // RL7
	end

	// Newest average shows once the freeze lifts; nothing is lost
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			loc_vis_reg <= tmon_pkg::RES_RESET;
			rem_vis_reg <= tmon_pkg::RES_RESET;
		end else if (!freeze_reg && !rd_frac) begin
			loc_vis_reg <= loc_avg; // RL1 RL4
			rem_vis_reg <= rem_avg;
		end
	end

	// ----------------------------------------------------------------
	// Limit comparisons on the newly stored averages
	// ----------------------------------------------------------------
	function automatic logic at_or_above(input logic [10:0] t,
		input logic [7:0] lim);
		at_or_above = $signed(t) >= $signed({lim, 3'h0});
	endfunction : at_or_above

	function automatic logic at_or_below(input logic [10:0] t,
		input logic [7:0] lim);
		at_or_below = $signed(t) <= $signed({lim, 3'h0});
	endfunction : at_or_below

	// Rearm point sits 5 degrees under the throttle limit, one bit wider
	function automatic logic rearm_ok(input logic [10:0] t,
		input logic [7:0] lim);
		logic [8:0] band;
		band     = {lim[7], lim} - tmon_pkg::THR_HYST;
		rearm_ok = $signed({t[10], t}) <= $signed({band, 3'h0});
	endfunction : rearm_ok

	logic l_hi, l_lo, r_hi, r_lo, l_cr, r_cr, l_th, r_th, psv_c;

	always_comb begin
		l_hi  = at_or_above(loc_avg, lhi_reg);   // RL8 RL21
		r_hi  = at_or_above(rem_avg, rhi_reg);   // RL8 RL21
		l_lo  = at_or_below(loc_avg, llo_reg);   // RL9
		r_lo  = at_or_below(rem_avg, rlo_reg);   // RL9
		l_cr  = at_or_above(loc_avg, lcrit_reg); // RL12
		r_cr  = at_or_above(rem_avg, rcrit_reg); // RL12
		l_th  = at_or_above(loc_avg, thr_reg);   // RL17
		r_th  = at_or_above(rem_avg, thr_reg);   // RL17
		psv_c = at_or_below(rem_avg, psv_reg);   // RL13
		if (cfg1_reg[tmon_pkg::B_FANMAX])
			psv_c = psv_c && at_or_below(loc_avg, psv_reg); // RL14
	end

	// ----------------------------------------------------------------
	// Status flags: set wins over the read that clears
	// ----------------------------------------------------------------
	logic [7:0] st1_reg;     // lth ltl rth rtl lto rto lct rct
	logic       psv_flag, lthr_flag, rthr_flag;
	logic       lthr_arm, rthr_arm;
	logic [7:0] st1_set;

	assign st1_set = eval ? {l_hi, l_lo, r_hi, r_lo,
		l_hi || l_lo, r_hi || r_lo, l_cr, r_cr} : 8'h00; // RL10 RL11

	// Flags only set on an evaluation, never before the first one
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			st1_reg <= 8'h00;
		else
			st1_reg <= st1_set | (st1_reg & {8{!rd_st1}}); // RL8 RL9
	end

	// Passive flag, cleared by a status 2 read
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			psv_flag <= 1'b0;
		else
			psv_flag <= (eval && psv_c) || (psv_flag && !rd_st2); // RL15 RL16
	end

	// Throttle flags disarm on a status 1 read until temperature drops
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			lthr_flag <= 1'b0;
			rthr_flag <= 1'b0;
			lthr_arm  <= 1'b1;
			rthr_arm  <= 1'b1;
		end else begin
			lthr_flag <= (eval && l_th && lthr_arm)
				|| (lthr_flag && !rd_st1); // RL17 RL18
			rthr_flag <= (eval && r_th && rthr_arm)
				|| (rthr_flag && !rd_st1); // RL17 RL18
			if (rd_st1 && lthr_flag)
				lthr_arm <= 1'b0; // RL18
			else if (eval && rearm_ok(loc_avg, thr_reg))
				lthr_arm <= 1'b1; // RL18
			if (rd_st1 && rthr_flag)
				rthr_arm <= 1'b0;
			else if (eval && rearm_ok(rem_avg, thr_reg))
				rthr_arm <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Live conditions for the pins and fan, held between cycles
	// ----------------------------------------------------------------
	logic crit_now, thr_now, psv_now;

	// Cleared on stop so a halted monitor raises no stale pin
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			crit_now <= 1'b0;
			thr_now  <= 1'b0;
			psv_now  <= 1'b0;
		end else if (!start) begin
			crit_now <= 1'b0;
			thr_now  <= 1'b0;
			psv_now  <= 1'b0;
		end else if (eval) begin
			crit_now <= l_cr || r_cr; // RL12 RL20
			thr_now  <= l_th || r_th; // RL17
			psv_now  <= psv_c;        // RL13 RL14
		end
	end

	assign over_temperature_pin_b = !crit_now; // RL12
	assign cpu_throttle_pin_b     = !thr_now;  // RL17
	assign fan_full = cfg3_reg[tmon_pkg::B_THRFAN]
		&& (lthr_flag || rthr_flag);            // RL19
	assign fan_stop = psv_now && !fan_full;   // RL13

	// Critical flags alert regardless of any enable
	assign alert_b = !(
		(st1_reg[3] && cfg2_reg[tmon_pkg::B_LOCAL_RANGE_IRQ_ENABLE])          // RL10
		|| (st1_reg[2] && cfg2_reg[tmon_pkg::B_REMOTE_RANGE_IRQ_ENABLE])       // RL11
		|| st1_reg[1] || st1_reg[0]                          // RL12
		|| (psv_flag && cfg2_reg[tmon_pkg::B_PASSIVE_COOLING_IRQ_ENABLE])         // RL15
		|| ((lthr_flag || rthr_flag)
			&& cfg2_reg[tmon_pkg::B_THRIE]));                 // RL17

	// ----------------------------------------------------------------
	// Read data, registered one cycle after the request
	// ----------------------------------------------------------------
	logic [7:0] rd_mux;

	// Unmapped offsets read as zero
	always_comb begin
		case (reg_req.addr)
			tmon_pkg::A_CFG1:  rd_mux = cfg1_reg;
			tmon_pkg::A_CFG2:  rd_mux = cfg2_reg;
			tmon_pkg::A_CFG3:  rd_mux = cfg3_reg;
			tmon_pkg::A_STAT1: rd_mux = st1_reg;
			tmon_pkg::A_STAT2: rd_mux = {5'h00, rthr_flag, lthr_flag,
				psv_flag};
			tmon_pkg::A_FRAC:  rd_mux = {rem_vis_reg[2:0], 1'b0,
				loc_vis_reg[2:0], 1'b0};              // RL3
			tmon_pkg::A_LOC:   rd_mux = loc_vis_reg[10:3]; // RL3 RL5
			tmon_pkg::A_REM:   rd_mux = rem_vis_reg[10:3]; // RL3 RL5
			tmon_pkg::A_LHI:   rd_mux = lhi_reg;
			tmon_pkg::A_LLO:   rd_mux = llo_reg;
			tmon_pkg::A_LCRIT: rd_mux = lcrit_reg;
			tmon_pkg::A_RHI:   rd_mux = rhi_reg;
			tmon_pkg::A_RLO:   rd_mux = rlo_reg;
			tmon_pkg::A_RCRIT: rd_mux = rcrit_reg;
			tmon_pkg::A_PSV:   rd_mux = psv_reg;
			tmon_pkg::A_THR:   rd_mux = thr_reg;
			default:           rd_mux = 8'h00;
		endcase
	end

	// Status reads return the value before their own clear
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			reg_rdata <= 8'h00;
		else if (reg_req.rd)
			reg_rdata <= rd_mux;
	end

endmodule : tmon_monitor

/* File: test/tmon_monitor_checker.sv */
// Port-level assertions for the temperature result and limit monitor
`timescale 1ns/1ns
module tmon_monitor_checker (
	input wire logic                   clk,                    // Clock
	input wire logic                   rst_b,                  // Reset low
	input wire tmon_pkg::tmon_req_t    reg_req,                // Reg access
	input wire logic [7:0]             reg_rdata,              // Read data
	input wire tmon_pkg::tmon_sample_t sample,                 // Samples
	input wire logic                   adc_run,                // Run level
	input wire logic                   over_temperature_pin_b, // Critical
	input wire logic                   cpu_throttle_pin_b,     // Throttle
	input wire logic                   alert_b,                // Alert
	input wire logic                   fan_stop,               // Passive
	input wire logic                   fan_full                // Forced
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);

	// Cycles since the last accepted sample; pins may only move soon after
	logic [3:0] quiet_cnt;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			quiet_cnt <= 4'hf;
		else if (sample.valid && adc_run)
			quiet_cnt <= 4'h0;
		else if (quiet_cnt != 4'hf)
			quiet_cnt <= quiet_cnt + 4'h1;
	end

	// ----------------------------------------------------------------
	// Register port
	// ----------------------------------------------------------------
	sequence s_frac_rd;
		reg_req.rd && reg_req.addr == tmon_pkg::A_FRAC;
	endsequence
	sequence s_loc_rd;
		reg_req.rd && reg_req.addr == tmon_pkg::A_LOC;
	endsequence
	property p_frozen_whole;
		s_frac_rd ##2 s_loc_rd ##2 s_loc_rd |=> $stable(reg_rdata);
	endproperty
	a_frozen_whole: assert property (p_frozen_whole)
		else $error("whole byte moved while frozen");
	property p_rdata_hold;
		!reg_req.rd |=> $stable(reg_rdata);
	endproperty
	a_rdata_hold: assert property (p_rdata_hold)
		else $error("read data moved without a read");
	property p_run_cfg;
		reg_req.wr && !reg_req.rd && reg_req.addr == tmon_pkg::A_CFG1
			|=> adc_run == $past(reg_req.wdata[tmon_pkg::B_START]);
	endproperty
	a_run_cfg: assert property (p_run_cfg)
		else $error("run level does not follow start bit");

	// ----------------------------------------------------------------
	// Pins and fan
	// ----------------------------------------------------------------
	property p_idle_pins;
		(!adc_run) [*3] |-> over_temperature_pin_b && cpu_throttle_pin_b;
	endproperty
	a_idle_pins: assert property (p_idle_pins)
		else $error("pin active while halted");
	property p_fan_stop;
		$rose(fan_stop) |-> quiet_cnt < 4'h8
			|| $past(reg_req.rd || reg_req.wr);
	endproperty
	a_fan_stop: assert property (p_fan_stop)
		else $error("fan stop rose away from an evaluation or access");
	property p_thr_timing;
		$fell(cpu_throttle_pin_b) |-> quiet_cnt < 4'h8;
	endproperty
	a_thr_timing: assert property (p_thr_timing)
		else $error("throttle pin fell away from an evaluation");
	property p_crit_timing;
		$fell(over_temperature_pin_b) |-> quiet_cnt < 4'h8;
	endproperty
	a_crit_timing: assert property (p_crit_timing)
		else $error("critical pin fell away from an evaluation");
	property p_crit_alert;
		$fell(over_temperature_pin_b) |-> !alert_b;
	endproperty
	a_crit_alert: assert property (p_crit_alert)
		else $error("critical without alert");
endmodule : tmon_monitor_checker

bind tmon_monitor tmon_monitor_checker u_chk (
	.clk(clk), .rst_b(rst_b), .reg_req(reg_req), .reg_rdata(reg_rdata),
	.sample(sample), .adc_run(adc_run),
	.over_temperature_pin_b(over_temperature_pin_b),
	.cpu_throttle_pin_b(cpu_throttle_pin_b), .alert_b(alert_b),
	.fan_stop(fan_stop), .fan_full(fan_full));

/* File: test/tmon_host.sv */
// Host model issuing register reads and writes to the monitor
`timescale 1ns/1ns
module tmon_host (
	input  wire logic          clk,       // Monitor clock
	output tmon_pkg::tmon_req_t reg_req,  // Register access
	input  wire logic [7:0]    reg_rdata  // Read data
);
	initial reg_req = '0;

	// One access per call, entered just after an edge; the strobe then
	// drops for an idle cycle so two calls never drive in one time step
	task automatic access(input logic rd, input logic [5:0] a,
		input logic [7:0] d, output logic [7:0] q);
		reg_req = '{rd, !rd, a, d};
		@(posedge clk);
		#1;
		q = reg_rdata;
		reg_req = '0;
		@(posedge clk);
		#1;
	endtask : access
endmodule : tmon_host

/* File: test/tmon_monitor_tb.sv */
// Self-checking bench for the temperature result and limit monitor
`timescale 1ns/1ns
module tmon_monitor_tb;
	logic                   clk;         // Monitor clock
	logic                   rst_b;       // Reset, active low
	tmon_pkg::tmon_req_t    reg_req;     // Host requests
	logic [7:0]             reg_rdata;   // Read data
	tmon_pkg::tmon_sample_t sample;      // Converter samples
	logic                   adc_run;     // Run level
	logic                   ot_b;        // Critical pin
	logic                   th_b;        // Throttle pin
	logic                   alert_b;     // Alert request
	logic                   fan_stop;    // Passive cooling
	logic                   fan_full;    // Forced full speed
	logic [7:0]             outs;        // Output levels in one byte
	logic [7:0]             q;           // Last read byte
	logic [10:0]            le;          // Expected local result
	logic [10:0]            re;          // Expected remote result
	int                     err_total;   // Mismatches
	int                     check_count; // Comparisons
	localparam logic [7:0] LIM [8] = '{tmon_pkg::HI_RESET,
		tmon_pkg::LO_RESET, tmon_pkg::CRIT_RESET, tmon_pkg::HI_RESET,
		tmon_pkg::LO_RESET, tmon_pkg::CRIT_RESET, tmon_pkg::PSV_RESET,
		tmon_pkg::THR_RESET};
	localparam logic [7:0] CFG2 [5] = '{8'h00, 8'h02, 8'h04, 8'h01, 8'h08};
	localparam logic [7:0] OUT2 [5] = '{8'h3e, 8'h3a, 8'h3a, 8'h3e, 8'h3e};

	assign outs = {2'b00, adc_run, ot_b, th_b, alert_b, fan_stop, fan_full};
	always #2 clk = ~clk;

	tmon_monitor uut (.clk(clk), .rst_b(rst_b), .reg_req(reg_req),
		.reg_rdata(reg_rdata), .sample(sample), .adc_run(adc_run),
		.over_temperature_pin_b(ot_b), .cpu_throttle_pin_b(th_b),
		.alert_b(alert_b), .fan_stop(fan_stop), .fan_full(fan_full));
	tmon_host host (.clk(clk), .reg_req(reg_req), .reg_rdata(reg_rdata));

	// ----------------------------------------------------------------
	// Expectation helpers
	// ----------------------------------------------------------------
	function automatic logic ge_lim(logic [10:0] v, logic [7:0] lim);
		return $signed(v) >= $signed({lim, 3'b000});
	endfunction : ge_lim
	function automatic logic le_lim(logic [10:0] v, logic [7:0] lim);
		return $signed(v) <= $signed({lim, 3'b000});
	endfunction : le_lim
	// Status byte for default limits, out-of-range derived from high/low
	function automatic logic [7:0] st1(logic [10:0] l, logic [10:0] r);
		logic [3:0] f;
		f = {ge_lim(l, LIM[0]), le_lim(l, LIM[1]), ge_lim(r, LIM[0]),
			le_lim(r, LIM[1])};
		return {f, f[3] | f[2], f[1] | f[0], ge_lim(l, LIM[2]),
			ge_lim(r, LIM[2])};
	endfunction : st1
	// Random target, about -40 to +125 degrees with a fraction
	function automatic logic [10:0] rnd_t();
		return 11'(int'($urandom_range(1320)) - 320);
	endfunction : rnd_t

	task automatic check(input string n, input logic [7:0] s,
		input logic [7:0] e);
		check_count++;
		if (s !== e) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask : check
	task automatic rdchk(input logic [5:0] a, input logic [7:0] e,
		input string n);
		host.access(1'b1, a, 8'h00, q);
		check(n, q, e);
	endtask : rdchk
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		host.access(1'b0, a, d, q);
	endtask : wr
	// 32 interleaved samples per channel, then time for the evaluation
	task automatic feed(input logic [10:0] lt, input logic [10:0] rt,
		input bit jit);
		int sl;
		int sr;
		int j;
		sl = 0;
		sr = 0;
		for (int i = 0; i < 64; i++) begin
			j = jit ? int'($urandom_range(6)) - 3 : 0;
			sample = '{1'b1, i[0], (i[0] ? rt : lt) + 11'(j)};
			if (i[0])
				sr += $signed(rt) + j;
			else
				sl += $signed(lt) + j;
			@(posedge clk);
			#1;
		end
		sample = '0;
		le = 11'(sl >>> 5);
		re = 11'(sr >>> 5);
		repeat (6) @(posedge clk);
		#1;
	endtask : feed
	task automatic test_done();
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : test_done

	// Guard against a hang anywhere in the sequence
	initial begin
		#100000;
		err_total++;
		$display("[FAIL] run expected finish seen timeout");
		test_done();
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		clk = 1'b0;
		rst_b = 1'b0;
		sample = '0;
		err_total = 0;
		check_count = 0;
		void'($urandom(32'hee6e));
		repeat (20) @(posedge clk);
		#1;
		rst_b = 1'b1;
		check("outs", outs, 8'h1c);
		rdchk(tmon_pkg::A_LOC, 8'h80, "loc");
		rdchk(tmon_pkg::A_FRAC, 8'h00, "frac");
		foreach (LIM[i]) begin
			rdchk(6'h10 + 6'(i), LIM[i], "limit");
		end
		rdchk(6'h3f, 8'h00, "unmapped");
		// Samples offered while halted must be dropped
		feed(11'h320, 11'h320, 1'b0);
		rdchk(tmon_pkg::A_REM, 8'h80, "rem halted");
		$display("test reset and halt done");
		wr(tmon_pkg::A_CFG2, 8'h0f);
		wr(tmon_pkg::A_CFG1, 8'h01);
		check("outs", outs, 8'h3c);
		rdchk(tmon_pkg::A_STAT1, 8'h00, "status1");
		// +100 local hits high, critical and throttle; -25 remote is low
		feed(11'h320, 11'h738, 1'b0);
		rdchk(tmon_pkg::A_LOC, 8'h64, "loc");
		rdchk(tmon_pkg::A_REM, 8'he7, "rem");
		check("outs", outs, 8'h22);
		rdchk(tmon_pkg::A_STAT2, 8'h03, "status2");
		rdchk(tmon_pkg::A_STAT2, 8'h02, "status2");
		rdchk(tmon_pkg::A_STAT1, st1(le, re), "status1");
		rdchk(tmon_pkg::A_STAT1, 8'h00, "status1");
		rdchk(tmon_pkg::A_STAT2, 8'h00, "status2");
		$display("test limits done");
		// Fraction read freezes both whole bytes across a new cycle
		rdchk(tmon_pkg::A_FRAC, 8'h00, "frac");
		feed(11'h320, 11'h7b0, 1'b0);
		rdchk(tmon_pkg::A_FRAC, 8'h00, "frac");
		rdchk(tmon_pkg::A_LOC, 8'h64, "loc");
		rdchk(tmon_pkg::A_LOC, 8'h64, "loc");
		rdchk(tmon_pkg::A_REM, 8'he7, "rem");
		rdchk(tmon_pkg::A_STAT2, 8'h01, "status2");
		feed(11'h2a8, 11'h7b0, 1'b0);
		rdchk(tmon_pkg::A_REM, 8'hf6, "rem");
		feed(11'h320, 11'h7b0, 1'b0);
		rdchk(tmon_pkg::A_STAT2, 8'h03, "status2");
		wr(tmon_pkg::A_CFG3, 8'h01);
		check("outs", outs, 8'h21);
		wr(tmon_pkg::A_CFG3, 8'h00);
		check("outs", outs, 8'h22);
		$display("test freeze and throttle done");
		// Faster-of-two mode needs both channels cool to stop the fan
		wr(tmon_pkg::A_CFG1, 8'h03);
		rdchk(tmon_pkg::A_STAT2, 8'h02, "status2");
		feed(11'h320, 11'h7b0, 1'b0);
		check("fan_stop", {7'h00, fan_stop}, 8'h00);
		feed(11'h0a0, 11'h7b0, 1'b0);
		check("fan_stop", {7'h00, fan_stop}, 8'h01);
		$display("test fan mode done");
		// Each alert enable alone against a remote-low, passive state
		wr(tmon_pkg::A_CFG1, 8'h01);
		host.access(1'b1, tmon_pkg::A_STAT1, 8'h00, q);
		feed(11'h0f0, 11'h7b0, 1'b0);
		foreach (CFG2[i]) begin
			wr(tmon_pkg::A_CFG2, CFG2[i]);
			check("outs", outs, OUT2[i]);
		end
		$display("test alert enables done");
		for (int k = 0; k < 4; k++) begin
			host.access(1'b1, tmon_pkg::A_STAT1, 8'h00, q);
			feed(rnd_t(), rnd_t(), 1'b1);
			rdchk(tmon_pkg::A_FRAC, {re[2:0], 1'b0, le[2:0], 1'b0}, "frac");
			rdchk(tmon_pkg::A_LOC, le[10:3], "loc");
			rdchk(tmon_pkg::A_REM, re[10:3], "rem");
			rdchk(tmon_pkg::A_STAT1, st1(le, re), "status1");
		end
		$display("test random done");
		test_done();
	end
endmodule : tmon_monitor_tb
